// *** test/bit_clear_call_exec_tb_top.sv ***
// Self-checking bench for the bit, clear and call executor
`timescale 1ns/1ps
module bit_clear_call_exec_tb_top;
    logic clk, rst_n, cyc_en, reg_wr_en, z_wr_en, z_wr_val;
    logic stack_push, discard;
    logic [13:0] instr;
    logic [12:0] fetch_addr, stack_top;
    logic [7:0] latch, reg_rd_data, reg_wr_data;
    logic [6:0] reg_addr, reg_wr_addr;
    int fail_count = 0, checks_done = 0, cyc = 0, z_n = 0, disc_n = 0;
    int hit_cyc = 0;

    bit_clear_call_exec u_dut (.clk(clk), .rst_n(rst_n), .cyc_en(cyc_en),
        .instr(instr), .fetch_addr(fetch_addr), .pc_upper_latch(latch),
        .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .z_wr_en(z_wr_en), .z_wr_val(z_wr_val),
        .stack_push(stack_push), .stack_top(stack_top), .discard(discard));
    exec_mem_model u_mem (.clk(clk), .fetch_addr(fetch_addr), .instr(instr),
        .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .stack_push(stack_push),
        .stack_top(stack_top));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Strobes are one clk wide, so count them at every edge
    always @(posedge clk) begin
        if (rst_n) begin
            cyc <= cyc + 1;
            if (z_wr_en === 1'b1 && z_wr_val === 1'b1) z_n <= z_n + 1;
            if (discard === 1'b1) disc_n <= disc_n + 1;
            if (reg_wr_en === 1'b1 && reg_wr_addr === 7'h16) begin
                hit_cyc <= cyc + 1;
            end
        end
        if (cyc > 1000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Set, clear, hit and miss skips, two calls; 0xf7 gives latch 4:3 = 10
    task automatic run_program();
        @(posedge clk);
        u_mem.prog[0] = {4'h5, 3'h7, 7'h10};
        u_mem.prog[1] = {7'h03, 7'h11};
        u_mem.prog[2] = {4'h7, 3'h7, 7'h10};
        u_mem.prog[3] = {7'h03, 7'h12};
        u_mem.prog[4] = {4'h7, 3'h2, 7'h13};
        u_mem.prog[5] = {7'h03, 7'h14};
        u_mem.prog[6] = {3'h4, 11'h7ff};
        u_mem.prog[7] = {7'h03, 7'h15};
        u_mem.prog[13'h17ff] = {3'h4, 11'h000};
        u_mem.prog[13'h1000] = {7'h03, 7'h16};
        u_mem.regs[7'h10] = 8'h0a;
        u_mem.regs[7'h11] = 8'h5a;
        u_mem.regs[7'h12] = 8'h33;
        u_mem.regs[7'h13] = 8'hfb;
        u_mem.regs[7'h14] = 8'hff;
        u_mem.regs[7'h15] = 8'h77;
        u_mem.regs[7'h16] = 8'h01;
        repeat (15) @(posedge clk);
        rst_n <= 1'b1;
        cyc_en <= 1'b1;
        repeat (40) @(posedge clk);
        // Look after the last edge's updates have settled
        @(negedge clk);
        check_bits();
        check_calls();
    endtask

    task automatic check_bits();
        chk(u_mem.regs[7'h10], 8'h8a);
        chk(u_mem.regs[7'h12], 8'h33);
        chk(u_mem.regs[7'h14], 8'h00);
        chk(u_mem.regs[7'h11], 8'h00);
        chk(z_n, 3);
    endtask

    task automatic check_calls();
        chk(u_mem.pushes[0], 13'h0007);
        chk(u_mem.pushes[1], 13'h1800);
        chk(u_mem.push_n, 2);
        chk(u_mem.regs[7'h15], 8'h77);
        chk(u_mem.regs[7'h16], 8'h00);
        chk(disc_n, 3);
        // Load, five one-cycle words, skip hit, then two calls of two
        chk(hit_cyc, 13);
        chk(fetch_addr, 13'h1000 + 13'h001 + 13'h001 * 29);
    endtask

    initial begin
        rst_n = 1'b0;
        cyc_en = 1'b0;
        latch = 8'hf7;
        run_program();
        wrap_up();
    end
endmodule

// *** test/exec_mem_model.sv ***
// Program memory, data register file and stack facing the executor
`timescale 1ns/1ps
module exec_mem_model (
    // Clock
    input wire logic clk,
    // Program memory
    input wire logic [12:0] fetch_addr,
    output logic [13:0] instr,
    // Data register file
    input wire logic [6:0] reg_addr,
    output logic [7:0] reg_rd_data,
    input wire logic reg_wr_en,
    input wire logic [6:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    // Stack
    input wire logic stack_push,
    input wire logic [12:0] stack_top
);
    logic [13:0] prog [0:8191];
    logic [7:0] regs [0:127];
    logic [12:0] pushes [0:7];
    int push_n = 0;
    initial begin
        foreach (prog[i]) prog[i] = 14'h0000;
    end
    // Combinational reads, as the executor samples them at cyc_en
    assign instr = prog[fetch_addr];
    assign reg_rd_data = regs[reg_addr];
    // Written on the strobe edge, so the word right after the writer still reads the old data
    always @(posedge clk) begin
        if (reg_wr_en) begin
            regs[reg_wr_addr] <= reg_wr_data;
        end
        if (stack_push) begin
            pushes[push_n[2:0]] <= stack_top;
            push_n <= push_n + 1;
        end
    end
endmodule

// *** verilog/bit_clear_call_exec.sv ***
// Fetch and execute of bit set, bit test skip, clear and call
// Function
// - Bit set forces one bit, one cycle
// - Set bit skips: fetched word becomes NOP
// - Clear writes zero, sets zero flag
// - Call pushes program counter plus one
// - Call loads eleven-bit target into PC low
// - Call loads PC 12:11 from latch 4:3
// - Call takes two cycles, one word
`timescale 1ns/1ps
module bit_clear_call_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction cycle and program memory
    input wire logic cyc_en,
    input wire logic [13:0] instr,
    output logic [12:0] fetch_addr,
    // Program counter upper latch
    input wire logic [7:0] pc_upper_latch,
    // Data register file
    output logic [6:0] reg_addr,
    input wire logic [7:0] reg_rd_data,
    output logic reg_wr_en,
    output logic [6:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    // Zero flag
    output logic z_wr_en,
    output logic z_wr_val,
    // Hardware stack
    output logic stack_push,
    output logic [12:0] stack_top,
    // Fetched word thrown away
    output logic discard
);
    typedef struct packed {
        logic [exec_pkg::PC_W-1:0] pc;
        logic [exec_pkg::WORD_W-1:0] ir;
        logic wr_en;
        logic [exec_pkg::ADDR_W-1:0] wr_addr;
        logic [exec_pkg::DATA_W-1:0] wr_data;
        logic z_we;
        logic z_val;
        logic push;
        logic [exec_pkg::PC_W-1:0] push_data;
        logic discard;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    decode_if d ();

    assign d.word = st_r.ir;

    word_decoder u_dec (
        .d(d)
    );

    always_comb begin
        st_nxt = st_r;
        // Strobes last one clock only
        st_nxt.wr_en = 1'b0;
        st_nxt.z_we = 1'b0;
        st_nxt.push = 1'b0;
        st_nxt.discard = 1'b0;
        if (cyc_en) begin
            st_nxt.ir = instr;
            st_nxt.pc = st_r.pc + 13'h0001;
            st_nxt.wr_addr = d.addr;
            unique case (d.op)
                exec_pkg::bit_force_high_op: begin
                    st_nxt.wr_en = 1'b1;
                    st_nxt.wr_data = reg_rd_data |
                        (exec_pkg::BIT_ONE << d.bit_sel);
                end
                exec_pkg::bit_check_skip_high_op: begin
                    // Flags stay put, only the pipeline changes
                    if (reg_rd_data[d.bit_sel]) begin
                        st_nxt.ir = exec_pkg::NOP_WORD;
                        st_nxt.discard = 1'b1;
                    end
                end
                exec_pkg::register_wipe_op: begin
                    st_nxt.wr_en = 1'b1;
                    st_nxt.wr_data = exec_pkg::DATA_ZERO;
                    st_nxt.z_we = 1'b1;
                    st_nxt.z_val = 1'b1;
                end
                exec_pkg::call_op: begin
                    // Word at pc is already the next one, so pc is PC+1
                    st_nxt.push = 1'b1;
                    st_nxt.push_data = st_r.pc;
                    st_nxt.pc = {pc_upper_latch[exec_pkg::LATCH_HI_LSB +: 2],
                                 d.target};
                    // Second cycle runs a NOP while the target is fetched
                    st_nxt.ir = exec_pkg::NOP_WORD;
                    st_nxt.discard = 1'b1;
                end
                exec_pkg::op_other: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{pc: exec_pkg::PC_RESET, ir: exec_pkg::NOP_WORD,
                      wr_en: 1'b0, wr_addr: '0,
                      wr_data: exec_pkg::DATA_ZERO, z_we: 1'b0,
                      z_val: 1'b0, push: 1'b0,
                      push_data: exec_pkg::PC_RESET, discard: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fetch_addr = st_r.pc;
    assign reg_addr = st_r.ir[exec_pkg::ADDR_LSB +: exec_pkg::ADDR_W];
    assign reg_wr_en = st_r.wr_en;
    assign reg_wr_addr = st_r.wr_addr;
    assign reg_wr_data = st_r.wr_data;
    assign z_wr_en = st_r.z_we;
    assign z_wr_val = st_r.z_val;
    assign stack_push = st_r.push;
    assign stack_top = st_r.push_data;
    assign discard = st_r.discard;

    // Checks
    logic ex_set;
    logic ex_skip_hit;
    logic ex_skip_miss;
    logic ex_wipe;
    logic ex_call;
    logic [7:0] set_expect;

    assign ex_set = cyc_en && d.op == exec_pkg::bit_force_high_op;
    assign ex_skip_hit = cyc_en && d.op == exec_pkg::bit_check_skip_high_op
        && reg_rd_data[d.bit_sel];
    assign ex_skip_miss = cyc_en && d.op == exec_pkg::bit_check_skip_high_op
        && !reg_rd_data[d.bit_sel];
    assign ex_wipe = cyc_en && d.op == exec_pkg::register_wipe_op;
    assign ex_call = cyc_en && d.op == exec_pkg::call_op;
    assign set_expect = reg_rd_data | (8'h01 << d.bit_sel);

    sequence nop_in_place;
        st_r.ir == exec_pkg::NOP_WORD && discard;
    endsequence

    // Plain advance: no discard, next word fetched
    sequence one_word_step;
        !discard && fetch_addr == $past(fetch_addr) + 13'h0001;
    endsequence

    AST_SET: assert property (@(posedge clk) disable iff (!rst_n)
        ex_set |=> reg_wr_en && reg_wr_data == $past(set_expect)
            && reg_wr_addr == $past(d.addr) && !z_wr_en)
        else $error("bit set wrote wrong value");

    AST_SKIP: assert property (@(posedge clk) disable iff (!rst_n)
        ex_skip_hit |=> nop_in_place and (fetch_addr == $past(fetch_addr) + 1))
        else $error("set bit did not discard next word");

    AST_NOSKIP: assert property (@(posedge clk) disable iff (!rst_n)
        ex_skip_miss |=> st_r.ir == $past(instr) && !discard && !reg_wr_en)
        else $error("clear bit discarded next word");

    AST_WIPE: assert property (@(posedge clk) disable iff (!rst_n)
        ex_wipe |=> reg_wr_en && reg_wr_data == 8'h00 && z_wr_en && z_wr_val
            ##1 z_wr_en == $past(ex_wipe)
            && reg_wr_en == $past(ex_set || ex_wipe))
        else $error("clear did not zero register and set flag");

    AST_PUSH: assert property (@(posedge clk) disable iff (!rst_n)
        ex_call |=> stack_push && stack_top == $past(fetch_addr))
        else $error("call pushed wrong return address");

    AST_TGT_LO: assert property (@(posedge clk) disable iff (!rst_n)
        ex_call |=> fetch_addr[10:0] == $past(d.target))
        else $error("call target low bits wrong");

    AST_TGT_HI: assert property (@(posedge clk) disable iff (!rst_n)
        ex_call |=> fetch_addr[12:11] == $past(pc_upper_latch[4:3]))
        else $error("call target high bits wrong");

    AST_CALL_TWO: assert property (@(posedge clk) disable iff (!rst_n)
        // Word holds until the next strobe, so that strobe runs the NOP
        ex_call |=> nop_in_place ##0 d.op == exec_pkg::op_other)
        else $error("call second cycle was not a NOP");

    AST_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
        z_wr_en |-> $past(ex_wipe))
        else $error("zero flag written by wrong operation");

    AST_SET_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        ex_set |=> one_word_step ##0 !stack_push)
        else $error("bit set did not finish in one cycle");

    AST_WIPE_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        ex_wipe |=> one_word_step ##0 !stack_push)
        else $error("clear did not finish in one cycle");

    // The NOP put in place of a discarded word must do nothing
    AST_NOP_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        cyc_en && d.op == exec_pkg::op_other
            |=> !reg_wr_en && !z_wr_en && !stack_push && !discard)
        else $error("no-operation word caused an action");

    AST_SKIP_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
        ex_skip_hit || ex_skip_miss |=> !z_wr_en && !stack_push)
        else $error("bit test changed flags or stack");

    AST_CALL_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
        ex_call |=> !z_wr_en && !reg_wr_en)
        else $error("call changed flags or a register");

    // A second push at once would lose a return address
    AST_PUSH_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        stack_push |=> !stack_push)
        else $error("push strobe held for two cycles");
endmodule

// *** verilog/decode_if.sv ***
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/1ps
interface decode_if;
    logic [exec_pkg::WORD_W-1:0] word;
    exec_pkg::op_t op;
    logic [2:0] bit_sel;
    logic [exec_pkg::ADDR_W-1:0] addr;
    logic [exec_pkg::TARGET_W-1:0] target;
    modport dec (input word, output op, bit_sel, addr, target);
    modport exec (output word, input op, bit_sel, addr, target);
endinterface

// *** verilog/exec_pkg.sv ***
// Shared constants and types for the bit, clear and call executor
package exec_pkg;
    localparam int WORD_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int TARGET_W = 11;
    // Opcode fields and their values
    localparam int BIT_OP_LSB = 10;
    localparam logic [3:0] BIT_FORCE_HIGH_CODE = 4'h5;
    localparam logic [3:0] BIT_CHECK_SKIP_HIGH_CODE = 4'h7;
    localparam int WIPE_OP_LSB = 7;
    localparam logic [6:0] REGISTER_WIPE_CODE = 7'h03;
    localparam int CALL_OP_LSB = 11;
    localparam logic [2:0] CALL_CODE = 3'h4;
    // Operand fields
    localparam int BIT_SEL_LSB = 7;
    localparam int ADDR_LSB = 0;
    localparam int TARGET_LSB = 0;
    localparam int LATCH_HI_LSB = 3;
    // Word executed in place of a discarded fetch
    localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
    // Reset values, zero data and the bit-set mask
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

    typedef enum logic [2:0] {
        op_other,
        bit_force_high_op,
        bit_check_skip_high_op,
        register_wipe_op,
        call_op
    } op_t;
endpackage

// *** verilog/word_decoder.sv ***
// Instruction word decoder for the four handled operations
`timescale 1ns/1ps
module word_decoder (
    // Word in, fields out
    decode_if.dec d
);
    always_comb begin
        d.bit_sel = d.word[exec_pkg::BIT_SEL_LSB +: 3];
        d.addr = d.word[exec_pkg::ADDR_LSB +: exec_pkg::ADDR_W];
        // Full eleven bits, so any target 0 to 2047 passes
        d.target = d.word[exec_pkg::TARGET_LSB +: exec_pkg::TARGET_W];
        d.op = exec_pkg::op_other;
        if (d.word[exec_pkg::CALL_OP_LSB +: 3] == exec_pkg::CALL_CODE) begin
            d.op = exec_pkg::call_op;
        end else if (d.word[exec_pkg::BIT_OP_LSB +: 4] ==
                     exec_pkg::BIT_FORCE_HIGH_CODE) begin
            d.op = exec_pkg::bit_force_high_op;
        end else if (d.word[exec_pkg::BIT_OP_LSB +: 4] ==
                     exec_pkg::BIT_CHECK_SKIP_HIGH_CODE) begin
            d.op = exec_pkg::bit_check_skip_high_op;
        end else if (d.word[exec_pkg::WIPE_OP_LSB +: 7] ==
                     exec_pkg::REGISTER_WIPE_CODE) begin
            d.op = exec_pkg::register_wipe_op;
        end
    end
endmodule
